// ---- irq_svc_defines.svh ----
`ifndef IRQ_SVC_DEFINES_SVH
`define IRQ_SVC_DEFINES_SVH

// register byte addresses
`define ADDR_CUR_PRIO 32'h01e0001c
`define ADDR_IN_SERVICE 32'h01e00020
`define ADDR_IRQ_CLEAR 32'h01e00024
`define ADDR_FIQ_CLEAR 32'h01e0003c
`define ADDR_CTRL 32'h01e00040
`define ADDR_EVT_STATUS 32'h01e00044
`define ADDR_EVT_MASK 32'h01e00048
`define ADDR_PENDING 32'h01e0004c
`define ADDR_FIQ_SELECT 32'h01e00050

// sources and fields
`define NUM_SRC 26
`define ORDER_RESET 8'h1b
`define ORDER_MSB 7
`define VEC_LSB 8
`define VEC_MSB 13
`define VEC_W 6
`define VECTOR_BASE 6'h20
`define CTRL_FIXED_BIT 12
`define CTRL_RESET 32'h00001000
`define GROUP_A_BASE 22
`define GROUP_STEP 6
`define LAST_RANK 2'h3

// event status bits
`define NUM_EVT 3
`define EVT_SVC_START 0
`define EVT_SVC_END 1
`define EVT_STRAY_CLEAR 2

`endif

// ---- irq_svc_pkg.sv ----
package irq_svc_pkg;
    typedef enum logic {SVC_IDLE, SVC_BUSY} svc_e;
    typedef logic [25:0] src_vec_t;
    typedef logic [7:0] order_t;
endpackage

// ---- arb_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface arb_if;
    import irq_svc_pkg::*;
    src_vec_t pending;
    order_t order;
    src_vec_t winner;
    logic [4:0] win_idx;
    logic valid;
    order_t rotated;
    modport ctl (output pending, output order, input winner, input win_idx, input valid,
        input rotated);
    modport arb (input pending, input order, output winner, output win_idx, output valid,
        output rotated);
endinterface
`default_nettype wire

// ---- input_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "irq_svc_defines.svh"
module input_sync #(
    parameter int W = `NUM_SRC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] rise
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    // two flops before use; only stable feeds the edge detect
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end else begin
            meta <= async_in;
            stable <= meta;
            prev <= stable;
        end
    end

    assign rise = stable & ~prev;
endmodule
`default_nettype wire

// ---- group_arbiter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "irq_svc_defines.svh"
module group_arbiter (
    arb_if.arb a
);
    import irq_svc_pkg::*;

    // rank of group g (0 = A) within the master order
    function automatic logic [1:0] rank_of(input order_t ord, input int g);
        rank_of = ord[`ORDER_MSB - 2*g -: 2];
    endfunction

    // groups first by current rank, slaves inside a group fixed by bit index,
    // then the ungrouped sources highest bit first
    always_comb begin
        logic found;
        logic [4:0] idx;
        int base;
        found = 1'b0;
        idx = 5'h00;
        base = 0;
        a.rotated = a.order;
        for (int r = 0; r < 4; r++) begin
            for (int g = 0; g < 4; g++) begin
                base = `GROUP_A_BASE - `GROUP_STEP * g;
                if (!found && rank_of(a.order, g) == 2'(r) && |a.pending[base +: 4]) begin
                    found = 1'b1;
                    for (int s = 0; s < 4; s++) begin
                        if (a.pending[base + s]) begin
                            idx = 5'(base + s);
                        end
                    end
                    // winner goes last, ranks behind it move up one
                    for (int h = 0; h < 4; h++) begin
                        if (rank_of(a.order, h) > 2'(r)) begin
                            a.rotated[`ORDER_MSB - 2*h -: 2] = rank_of(a.order, h) - 2'h1;
                        end
                    end
                    a.rotated[`ORDER_MSB - 2*g -: 2] = `LAST_RANK;
                end
            end
        end
        for (int b = 0; b < `NUM_SRC; b++) begin
            if (!found && a.pending[b] && ((b % `GROUP_STEP) < 4 || b > `GROUP_A_BASE + 3)) begin
                idx = 5'(b);
            end
        end
        for (int b = 0; b < `NUM_SRC; b++) begin
            if (!found && a.pending[b] && ((b % `GROUP_STEP) < 4 || b > `GROUP_A_BASE + 3)) begin
                found = 1'b1;
            end
        end
        a.valid = found;
        a.win_idx = idx;
        a.winner = found ? (src_vec_t'(1) << idx) : '0;
    end
endmodule
`default_nettype wire

// ---- irq_status_clear.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "irq_svc_defines.svh"
// Functional notes
// - read-only register reports current priority order of the four groups
// - order field bits 7:0, reset 00011011, group a top pair to d
// - bits 13:8 return low six bits of branch code of chosen source
// - in-service register shows at most one bit set
// - in-service is read-only, reset zero, bit 25 ext input 0 down to bit 0
// - writing one to a clear bit clears that pending bit, zero leaves it
// - any write to a clear register ends the service and releases in-service
// - pending flags cannot be written directly, only cleared via clear registers
// - misuse may leave in-service and pending zero despite a request
// - separate write-only irq and fiq clear registers at distinct addresses
// - clear bit map equals in-service map, shared bits 21 and 14
// - round-robin rotates current order away from programmed order
// - master round-robin when control bit 12 is zero, fixed when one
module irq_status_clear (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire irq_svc_pkg::src_vec_t irq_request,
    output logic irq_to_core,
    output logic fiq_to_core,
    output logic int_out
);
    import irq_svc_pkg::*;

    arb_if arb ();

    src_vec_t req_rise;
    src_vec_t interrupt_pending_flags;
    src_vec_t irq_in_service_status;
    src_vec_t fiq_select;
    order_t current_master_order;
    logic [`VEC_W-1:0] vector_code;
    logic [31:0] ctrl;
    logic [`NUM_EVT-1:0] evt_status;
    logic [`NUM_EVT-1:0] evt_mask;
    svc_e svc_state;
    logic [31:0] rdata_mux;

    input_sync #(.W(`NUM_SRC)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(irq_request),
        .rise(req_rise)
    );

    group_arbiter u_arb (
        .a(arb.arb)
    );

    // bus decode; an access completes on the edge where waitrequest is low
    wire req = avs_read | avs_write;
    wire wr_done = avs_write & ~avs_waitrequest;
    wire hit_prio = avs_address == `ADDR_CUR_PRIO;
    wire hit_iss = avs_address == `ADDR_IN_SERVICE;
    wire hit_iclr = avs_address == `ADDR_IRQ_CLEAR;
    wire hit_fclr = avs_address == `ADDR_FIQ_CLEAR;
    wire hit_ctrl = avs_address == `ADDR_CTRL;
    wire hit_stat = avs_address == `ADDR_EVT_STATUS;
    wire hit_mask = avs_address == `ADDR_EVT_MASK;
    wire hit_pend = avs_address == `ADDR_PENDING;
    wire hit_fsel = avs_address == `ADDR_FIQ_SELECT;
    wire clr_wr = wr_done & (hit_iclr | hit_fclr);
    wire [`NUM_SRC-1:0] clr_bits = clr_wr ? avs_writedata[`NUM_SRC-1:0] : '0;
    wire fixed_mode = ctrl[`CTRL_FIXED_BIT];

    // arbitration request: irq-routed pending sources only
    assign arb.pending = interrupt_pending_flags & ~fiq_select;
    assign arb.order = current_master_order;
    wire start_svc = (svc_state == SVC_IDLE) & arb.valid & ~clr_wr;

    // read mux; clear registers are write-only and read zero
    always_comb begin
        rdata_mux = 32'h0000_0000;
        if (hit_prio) begin
            rdata_mux[`ORDER_MSB:0] = current_master_order;
            rdata_mux[`VEC_MSB:`VEC_LSB] = vector_code;
        end else if (hit_iss) begin
            rdata_mux[`NUM_SRC-1:0] = irq_in_service_status;
        end else if (hit_ctrl) begin
            rdata_mux = ctrl;
        end else if (hit_stat) begin
            rdata_mux[`NUM_EVT-1:0] = evt_status;
        end else if (hit_mask) begin
            rdata_mux[`NUM_EVT-1:0] = evt_mask;
        end else if (hit_pend) begin
            rdata_mux[`NUM_SRC-1:0] = interrupt_pending_flags;
        end else if (hit_fsel) begin
            rdata_mux[`NUM_SRC-1:0] = fiq_select;
        end
    end

    // one wait cycle per access, readdata registered with it
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= rdata_mux;
            end
        end
    end

    // software-written configuration; read-only addresses ignore writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= `CTRL_RESET;
            evt_mask <= '0;
            fiq_select <= '0;
        end else if (wr_done) begin
            if (hit_ctrl) ctrl <= avs_writedata;
            if (hit_mask) evt_mask <= avs_writedata[`NUM_EVT-1:0];
            if (hit_fsel) fiq_select <= avs_writedata[`NUM_SRC-1:0];
        end
    end

    // pending flags: new edges win over a same-cycle clear, no direct write path
    always_ff @(posedge clk) begin
        if (rst) begin
            interrupt_pending_flags <= '0;
        end else begin
            interrupt_pending_flags <= (interrupt_pending_flags & ~clr_bits) | req_rise;
        end
    end

    // service tracking: one-hot latch of the arbiter's winner
    always_ff @(posedge clk) begin
        if (rst) begin
            svc_state <= SVC_IDLE;
            irq_in_service_status <= '0;
            vector_code <= '0;
            current_master_order <= `ORDER_RESET;
        end else begin
            case (svc_state)
                SVC_IDLE: begin
                    if (start_svc) begin
                        svc_state <= SVC_BUSY;
                        irq_in_service_status <= arb.winner;
                        vector_code <= `VECTOR_BASE + `VEC_W'(arb.win_idx);
                        if (!fixed_mode) begin
                            current_master_order <= arb.rotated;
                        end
                    end
                end
                SVC_BUSY: begin
                    if (clr_wr) begin
                        svc_state <= SVC_IDLE;
                        irq_in_service_status <= '0;
                    end
                end
                default: begin
                    svc_state <= SVC_IDLE;
                    irq_in_service_status <= '0;
                end
            endcase
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    wire [`NUM_EVT-1:0] evt_set = {clr_wr & (svc_state == SVC_IDLE),
        clr_wr & (svc_state == SVC_BUSY), start_svc};
    wire [`NUM_EVT-1:0] evt_clr = (wr_done & hit_stat) ? avs_writedata[`NUM_EVT-1:0] : '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            evt_status <= '0;
        end else begin
            evt_status <= (evt_status & ~evt_clr) | evt_set;
        end
    end

    // core request lines and summary interrupt, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_to_core <= 1'b0;
            fiq_to_core <= 1'b0;
            int_out <= 1'b0;
        end else begin
            irq_to_core <= (svc_state == SVC_BUSY) & ~clr_wr;
            fiq_to_core <= |(interrupt_pending_flags & fiq_select & ~clr_bits);
            int_out <= |(evt_status & evt_mask);
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_onehot_service;
        $onehot0(irq_in_service_status);
    endproperty
    a_onehot_service: assert property (p_onehot_service) else $error("in-service not one-hot");

    property p_reserved_zero;
        avs_read && !avs_waitrequest && $past(hit_prio) |-> avs_readdata[15:14] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

    property p_clear_releases;
        clr_wr |=> irq_in_service_status == '0;
    endproperty
    a_clear_releases: assert property (p_clear_releases) else $error("service not released");

    property p_clear_bit;
        clr_wr && avs_writedata[0] && !req_rise[0] |=> !interrupt_pending_flags[0];
    endproperty
    a_clear_bit: assert property (p_clear_bit) else $error("pending bit not cleared");

    property p_zero_keeps;
        clr_wr && !avs_writedata[5] && interrupt_pending_flags[5] |=> interrupt_pending_flags[5];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed pending");

    property p_no_direct;
        !clr_wr |=> (interrupt_pending_flags & ~$past(interrupt_pending_flags)) == $past(req_rise)
            || interrupt_pending_flags == ($past(interrupt_pending_flags) | $past(req_rise));
    endproperty
    a_no_direct: assert property (p_no_direct) else $error("pending changed without clear");

    property p_fixed_order;
        fixed_mode && $stable(ctrl) |=> $stable(current_master_order);
    endproperty
    a_fixed_order: assert property (p_fixed_order) else $error("order moved in fixed mode");

    property p_rr_rotate;
        start_svc && !fixed_mode |=> current_master_order == $past(arb.rotated);
    endproperty
    a_rr_rotate: assert property (p_rr_rotate) else $error("order did not rotate");

    property p_ro_write;
        wr_done && (hit_iss || hit_prio) && svc_state == SVC_IDLE && !arb.valid
            |=> $stable(irq_in_service_status) && $stable(current_master_order);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only register written");

    property p_wait_one;
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer timing wrong");

    // a lost or doubled rank would starve one group for good
    property p_order_perm;
        ((4'h1 << current_master_order[7:6]) | (4'h1 << current_master_order[5:4])
            | (4'h1 << current_master_order[3:2])
            | (4'h1 << current_master_order[1:0])) == 4'hf;
    endproperty
    a_order_perm: assert property (p_order_perm) else $error("order ranks not distinct");

    property p_vector_code;
        start_svc |=> vector_code == `VECTOR_BASE + `VEC_W'($past(arb.win_idx));
    endproperty
    a_vector_code: assert property (p_vector_code) else $error("vector field wrong");

    property p_start_onehot;
        start_svc |=> $onehot(irq_in_service_status);
    endproperty
    a_start_onehot: assert property (p_start_onehot) else $error("no single source latched");

    // in-service must always name a source that is still pending
    property p_service_pending;
        (irq_in_service_status & ~interrupt_pending_flags) == '0;
    endproperty
    a_service_pending: assert property (p_service_pending) else $error("service without pending");

    property p_idle_empty;
        svc_state == SVC_IDLE |-> irq_in_service_status == '0;
    endproperty
    a_idle_empty: assert property (p_idle_empty) else $error("in-service set while idle");

    // a new edge must land even under a same-cycle clear
    property p_edge_sets;
        req_rise != '0 |=> (interrupt_pending_flags & $past(req_rise)) == $past(req_rise);
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("request edge lost");

    property p_stray_event;
        clr_wr && svc_state == SVC_IDLE |=> evt_status[`EVT_STRAY_CLEAR];
    endproperty
    a_stray_event: assert property (p_stray_event) else $error("stray clear not flagged");

    property p_clear_reads_zero;
        avs_read && avs_waitrequest && (hit_iclr || hit_fclr) |=> avs_readdata == 32'h0000_0000;
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear reg readable");

    property p_irq_line;
        svc_state == SVC_BUSY && !clr_wr |=> irq_to_core;
    endproperty
    a_irq_line: assert property (p_irq_line) else $error("core request missing");

    // summary line follows status and mask one cycle later
    property p_int_high;
        |(evt_status & evt_mask) |=> int_out;
    endproperty
    a_int_high: assert property (p_int_high) else $error("interrupt line low");

    property p_int_low;
        !(|(evt_status & evt_mask)) |=> !int_out;
    endproperty
    a_int_low: assert property (p_int_low) else $error("interrupt line high");

    c_service: cover property (start_svc ##[1:20] clr_wr);
    c_rotate: cover property (start_svc && !fixed_mode && arb.rotated != current_master_order);
    c_stray: cover property (evt_set[`EVT_STRAY_CLEAR]);
    c_fiq: cover property (fiq_to_core);
endmodule
`default_nettype wire

// ---- req_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// request sources on the far side; pins rest low between events
module req_model (
    input wire logic clk,
    output var irq_svc_pkg::src_vec_t req
);
    import irq_svc_pkg::*;
    initial req = '0;
    // four cycles high so the two-flop synchroniser cannot miss the edge
    task automatic pulse(input src_vec_t m);
        @(posedge clk);
        req <= m;
        repeat (4) @(posedge clk);
        req <= '0;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "irq_svc_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    import irq_svc_pkg::*;
    logic clk, rst, avs_read, avs_write, avs_waitrequest, irq_to_core, fiq_to_core, int_out;
    logic [31:0] avs_address, avs_writedata, avs_readdata, rdata;
    src_vec_t irq_request;
    int err_count = 0;
    int samples_checked = 0;
    int srcs[4] = '{25, 21, 14, 0};
    logic [5:0] vec;

    irq_status_clear i_irq_status_clear (
        .clk(clk),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .irq_request(irq_request),
        .irq_to_core(irq_to_core),
        .fiq_to_core(fiq_to_core),
        .int_out(int_out)
    );
    req_model i_req_model (.clk(clk), .req(irq_request));

    // 50 mhz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one avalon access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            err_count++;
            $display("BAD %0t bus hang", $time);
            final_report();
        end
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        `CHK(rdata, exp)
    endtask

    // bounded wait; the source pins need a few cycles to reach pending
    task automatic wait_core(input logic lvl);
        int n;
        for (n = 0; n < 30 && irq_to_core !== lvl; n++) @(posedge clk);
        `CHK(irq_to_core, lvl)
        if (n >= 30) final_report();
    endtask

    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // reset values; writes to read-only places must not stick
        rd(`ADDR_CUR_PRIO, 32'h0000001b);
        rd(`ADDR_IN_SERVICE, 32'h0);
        bus(1'b1, `ADDR_CUR_PRIO, 32'hffffffff);
        bus(1'b1, `ADDR_IN_SERVICE, 32'hffffffff);
        rd(`ADDR_CUR_PRIO, 32'h0000001b);
        rd(`ADDR_IN_SERVICE, 32'h0);
        rd(32'h01e00030, 32'h0);
        rd(`ADDR_IRQ_CLEAR, 32'h0);
        $display("test reset_values done");
        // two sources at once: the group a one is serviced first, then the group d one
        i_req_model.pulse(26'h2000010);
        wait_core(1'b1);
        rd(`ADDR_IN_SERVICE, 32'h02000000);
        rd(`ADDR_PENDING, 32'h02000010);
        bus(1'b1, `ADDR_IRQ_CLEAR, 32'h02000000);
        repeat (3) @(posedge clk);
        rd(`ADDR_IN_SERVICE, 32'h00000010);
        rd(`ADDR_PENDING, 32'h00000010);
        bus(1'b1, `ADDR_PENDING, 32'h0);
        bus(1'b1, `ADDR_IRQ_CLEAR, 32'h0);
        repeat (3) @(posedge clk);
        rd(`ADDR_PENDING, 32'h00000010);
        bus(1'b1, `ADDR_FIQ_CLEAR, 32'h00000010);
        wait_core(1'b0);
        rd(`ADDR_PENDING, 32'h0);
        rd(`ADDR_IN_SERVICE, 32'h0);
        $display("test two_sources done");
        // end and shared bit positions, fixed order keeps 0x1b
        foreach (srcs[i]) begin
            vec = `VECTOR_BASE + 6'(srcs[i]);
            i_req_model.pulse(26'(1) << srcs[i]);
            wait_core(1'b1);
            rd(`ADDR_IN_SERVICE, 32'(1) << srcs[i]);
            rd(`ADDR_CUR_PRIO, {16'h0, 2'b00, vec, 8'h1b});
            bus(1'b1, `ADDR_IRQ_CLEAR, 32'(1) << srcs[i]);
            wait_core(1'b0);
            rd(`ADDR_PENDING, 32'h0);
        end
        $display("test bit_map done");
        // round robin: the winning group drops to last place
        bus(1'b1, `ADDR_CTRL, 32'h0);
        i_req_model.pulse(26'h2000000);
        wait_core(1'b1);
        rd(`ADDR_CUR_PRIO, 32'h000039c6);
        bus(1'b1, `ADDR_IRQ_CLEAR, 32'h02000000);
        wait_core(1'b0);
        i_req_model.pulse(26'h0000010);
        wait_core(1'b1);
        rd(`ADDR_CUR_PRIO, 32'h00002487);
        bus(1'b1, `ADDR_IRQ_CLEAR, 32'h00000010);
        wait_core(1'b0);
        $display("test round_robin done");
        // fiq routed source stays out of the irq service
        bus(1'b1, `ADDR_FIQ_SELECT, 32'h1);
        i_req_model.pulse(26'h0000001);
        repeat (3) @(posedge clk);
        `CHK(fiq_to_core, 1'b1)
        `CHK(irq_to_core, 1'b0)
        bus(1'b1, `ADDR_FIQ_CLEAR, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(fiq_to_core, 1'b0)
        // event interrupt: raise by unmasking, drop by w1c
        rd(`ADDR_EVT_STATUS, 32'h7);
        bus(1'b1, `ADDR_EVT_MASK, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(int_out, 1'b1)
        bus(1'b1, `ADDR_EVT_STATUS, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(int_out, 1'b0)
        rd(`ADDR_EVT_STATUS, 32'h6);
        $display("test events done");
        final_report();
    end
endmodule
`default_nettype wire
